/* logic/lag_pkg.sv */
// Shared types and constants for the trunk-group port selector.
// Assumes a single 100 MHz clock and an AXI4-Lite register master.
// How it works
// - Six groups, two to eight members
// - Members act as one logical port
// - Same destination uses same member while the set of linked members is unchanged
// - Failed member's traffic spreads over linked members
// - Master port configuration covers all members
// - Spanning tree uses master port state
// - Blocking applies to whole group
package lag_pkg;
	localparam int          NPORT      = 28;
	localparam int          NGRP       = 6;
	localparam logic [5:0]  MIN_MEM    = 6'h02;
	localparam logic [5:0]  MAX_MEM    = 6'h08;
	localparam logic [4:0]  PORT_LIMIT = 5'h1c;

	// Register byte offsets; group g control at GRP_BASE + 8g, members 4 above it
	localparam logic [7:0]  GRP_BASE   = 8'h00;
	localparam logic [7:0]  GRP_STRIDE = 8'h08;
	localparam logic [7:0]  MEM_OFS    = 8'h04;
	localparam logic [7:0]  LINK_ADDR  = 8'h30;
	localparam logic [7:0]  STATE_ADDR = 8'h34;

	// Field positions
	localparam int          EN_BIT     = 0;
	localparam int          MST_LSB    = 8;
	localparam int          OK_LSB     = 0;
	localparam int          ERR_LSB    = 8;

	// Decoded register selector
	localparam logic [4:0]  SEL_LINK   = 5'h0c;
	localparam logic [4:0]  SEL_STATE  = 5'h0d;
	localparam logic [4:0]  SEL_NONE   = 5'h1f;

	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;

	typedef logic [NPORT-1:0] pmask_t;
	typedef logic [4:0]       pidx_t;

	typedef struct packed {
		logic   en;
		pidx_t  master;
		pmask_t members;
	} grp_cfg_t;

	typedef struct packed {
		logic [47:0] da;
		pidx_t       lport;
	} fwd_req_t;

	typedef struct packed {
		pidx_t egress;
		logic  drop;
	} fwd_ans_t;
endpackage

/* logic/member_pick.sv */
// Picks one set bit of a member mask by a hash value.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module member_pick
	import lag_pkg::*;
(
	input  wire pmask_t     mask,
	input  wire logic [7:0] hash,
	output pidx_t           pick,
	output logic            none
);
	logic [5:0] cnt;
	logic [7:0] k;
	logic [7:0] seen;

	always_comb begin
		cnt  = '0;
		k    = '0;
		seen = '0;
		pick = '0;
		for (int p = 0; p < NPORT; p++) begin
			cnt = cnt + {5'h00, mask[p]};
		end
		none = (cnt == 6'h00);
		if (!none) begin
			k = hash % {2'h0, cnt};
		end
		for (int p = 0; p < NPORT; p++) begin
			if (mask[p]) begin
				if (seen == k) begin
					pick = 5'(p);
				end
				seen = seen + 8'h01;
			end
		end
	end
endmodule

/* logic/link_aggregation_port_select.sv */
// Trunk-group port selector with an AXI4-Lite register slave.
// Assumes link, spanning-tree and request inputs synchronous to mclk.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module link_aggregation_port_select
	import lag_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire pmask_t      link_up,
	input  wire pmask_t      stp_fwd,
	input  wire logic        req_valid,
	input  wire fwd_req_t    req,
	output logic             ans_valid,
	output fwd_ans_t         ans,
	output pidx_t [NPORT-1:0] port_lport,
	output pmask_t           port_fwd
);
	typedef struct packed {
		grp_cfg_t [NGRP-1:0]  grp;
		logic                 awready;
		logic                 wready;
		logic                 have_aw;
		logic                 have_w;
		logic [7:0]           awaddr;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 arready;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic                 ans_valid;
		fwd_ans_t             ans;
		pidx_t [NPORT-1:0]    port_lport;
		pmask_t               port_fwd;
	} st_t;

	st_t              st_ff;
	st_t              nxt_st;
	logic [NGRP-1:0]  grp_ok;
	logic [NGRP-1:0]  grp_err;
	pmask_t           taken;
	pmask_t           pick_mask;
	logic [7:0]       hash;
	pidx_t            pick;
	logic             pick_none;
	logic             hit;
	logic [4:0]       wsel;
	logic [4:0]       rsel;
	logic [31:0]      old_word;
	logic [31:0]      new_word;
	logic [5:0]       grp_cnt [NGRP];

	function automatic logic [4:0] reg_sel(input logic [7:0] a);
		logic [4:0] s;
		// Misaligned or unmapped offsets stay at SEL_NONE
		s = SEL_NONE;
		if (a[1:0] == 2'h0) begin
			if (a < LINK_ADDR) begin
				s = a[6:2] - GRP_BASE[6:2];
			end else if (a == LINK_ADDR) begin
				s = SEL_LINK;
			end else if (a == STATE_ADDR) begin
				s = SEL_STATE;
			end
		end
		return s;
	endfunction

	function automatic logic [5:0] popc(input pmask_t m);
		logic [5:0] c;
		c = '0;
		for (int p = 0; p < NPORT; p++) begin
			c = c + {5'h00, m[p]};
		end
		return c;
	endfunction

	function automatic logic [31:0] ctrl_word(input grp_cfg_t g);
		logic [31:0] w;
		w = RST_WORD;
		w[EN_BIT] = g.en;
		w[MST_LSB +: 5] = g.master;
		return w;
	endfunction

	function automatic logic [31:0] grp_word(input st_t s, input logic [4:0] sel);
		logic [31:0] w;
		w = RST_WORD;
		for (int g = 0; g < NGRP; g++) begin
			if (sel == 5'(2 * g)) begin
				w = ctrl_word(s.grp[g]);
			end else if (sel == 5'(2 * g + 1)) begin
				w = {{(32 - NPORT){1'b0}}, s.grp[g].members};
			end
		end
		return w;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] w;
		w = o;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				w[8*b +: 8] = d[8*b +: 8];
			end
		end
		return w;
	endfunction

	// Destination address folded to eight bits
	always_comb begin
		hash = '0;
		for (int i = 0; i < 6; i++) begin
			hash = hash ^ req.da[8*i +: 8];
		end
	end

	member_pick u_pick (
		.mask (pick_mask),
		.hash (hash),
		.pick (pick),
		.none (pick_none)
	);

	assign wsel = reg_sel(st_ff.awaddr);
	assign rsel = reg_sel(s_axi_araddr);
	assign old_word = grp_word(st_ff, wsel);
	// Write word with the byte strobes applied over the current contents
	assign new_word = merge(old_word, st_ff.wdata, st_ff.wstrb);

	// Member count of each group for the size check
	for (genvar g = 0; g < NGRP; g++) begin : g_cnt
		assign grp_cnt[g] = popc(st_ff.grp[g].members);
	end

	// Group checks, port mapping and frame steering
	always_comb begin
		taken     = '0;
		grp_ok    = '0;
		grp_err   = '0;
		pick_mask = '0;
		hit       = 1'b0;
		for (int g = 0; g < NGRP; g++) begin
			// Illegal sizes, absent master or overlap disable the group
			if (st_ff.grp[g].en) begin
				if (grp_cnt[g] >= MIN_MEM &&
					grp_cnt[g] <= MAX_MEM &&
					st_ff.grp[g].master < PORT_LIMIT &&
					st_ff.grp[g].members[st_ff.grp[g].master] &&
					(st_ff.grp[g].members & taken) == '0) begin
					grp_ok[g] = 1'b1;
					taken = taken | st_ff.grp[g].members;
				end else begin
					grp_err[g] = 1'b1;
				end
			end
			if (grp_ok[g] && st_ff.grp[g].master == req.lport) begin
				hit = 1'b1;
				pick_mask = st_ff.grp[g].members & link_up;
			end
		end
	end

	always_comb begin
		nxt_st = st_ff;

		// Members inherit the master's identity and spanning-tree state
		for (int p = 0; p < NPORT; p++) begin
			nxt_st.port_lport[p] = 5'(p);
			nxt_st.port_fwd[p] = stp_fwd[p];
			for (int g = 0; g < NGRP; g++) begin
				if (grp_ok[g] && st_ff.grp[g].members[p]) begin
					nxt_st.port_lport[p] = st_ff.grp[g].master;
					nxt_st.port_fwd[p] = stp_fwd[st_ff.grp[g].master];
				end
			end
		end

		// One answer per request, one cycle later
		nxt_st.ans_valid = req_valid;
		if (hit) begin
			nxt_st.ans.egress = pick;
			nxt_st.ans.drop = pick_none;
		end else begin
			nxt_st.ans.egress = req.lport;
			// Ports past the last one have no link bit and are always dropped
			nxt_st.ans.drop = 1'b1;
			if (req.lport < PORT_LIMIT) begin
				nxt_st.ans.drop = !link_up[req.lport];
			end
		end

		// Write address and data are taken in either order
		if (s_axi_awvalid && st_ff.awready) begin
			nxt_st.have_aw = 1'b1;
			nxt_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_ff.wready) begin
			nxt_st.have_w = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end
		if (st_ff.have_aw && st_ff.have_w && !st_ff.bvalid) begin
			nxt_st.have_aw = 1'b0;
			nxt_st.have_w = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = RESP_OKAY;
			if (wsel < SEL_LINK) begin
				for (int g = 0; g < NGRP; g++) begin
					if (wsel == 5'(2 * g)) begin
						nxt_st.grp[g].en = new_word[EN_BIT];
						nxt_st.grp[g].master = new_word[MST_LSB +: 5];
					end else if (wsel == 5'(2 * g + 1)) begin
						nxt_st.grp[g].members = new_word[NPORT-1:0];
					end
				end
			end else if (wsel == SEL_NONE) begin
				nxt_st.bresp = RESP_SLV;
			end
		end
		// Response drops once the master takes it
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// A held address or data word closes its channel until the write is done
		nxt_st.awready = !nxt_st.have_aw;
		nxt_st.wready = !nxt_st.have_w;

		// Reads answer one cycle after the address is taken
		if (s_axi_arvalid && st_ff.arready) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = RESP_OKAY;
			case (rsel)
				SEL_LINK: begin
					nxt_st.rdata = {{(32 - NPORT){1'b0}}, link_up};
				end
				SEL_STATE: begin
					nxt_st.rdata = RST_WORD;
					nxt_st.rdata[OK_LSB +: NGRP] = grp_ok;
					nxt_st.rdata[ERR_LSB +: NGRP] = grp_err;
				end
				SEL_NONE: begin
					nxt_st.rdata = RST_WORD;
					nxt_st.rresp = RESP_SLV;
				end
				default: begin
					nxt_st.rdata = grp_word(st_ff, rsel);
				end
			endcase
		end
		// Read channel reopens once the data is taken
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
			nxt_st.arready = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// Ready flags come up high so the first request is taken at once
			st_ff <= '0;
			st_ff.awready <= 1'b1;
			st_ff.wready <= 1'b1;
			st_ff.arready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready  = st_ff.wready;
	assign s_axi_bvalid  = st_ff.bvalid;
	assign s_axi_bresp   = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid  = st_ff.rvalid;
	assign s_axi_rdata   = st_ff.rdata;
	assign s_axi_rresp   = st_ff.rresp;
	assign ans_valid     = st_ff.ans_valid;
	assign ans           = st_ff.ans;
	assign port_lport    = st_ff.port_lport;
	assign port_fwd      = st_ff.port_fwd;
endmodule

/* tb/link_peer.sv */
// Model of the Ethernet link partners on the 28 member ports.
// Assumes the bench commands which links are cut; runs on mclk.
`timescale 1ns/1ps
module link_peer
	import lag_pkg::*;
(
	input  wire logic   mclk,
	input  wire pmask_t cut,
	output pmask_t      link_up
);
	initial link_up = '1;
	// Every peer runs one common full-duplex speed; only link loss is modelled
	always @(posedge mclk) link_up <= ~cut;
endmodule

/* tb/lag_monitor.sv */
// Port-level checker for the trunk-group selector.
// Assumes it is bound to link_aggregation_port_select.
`timescale 1ns/1ps
module lag_monitor
	import lag_pkg::*;
(
	input  wire logic     mclk,
	input  wire logic     rst_n,
	input  wire logic     s_axi_awvalid,
	input  wire logic     s_axi_awready,
	input  wire logic     s_axi_wvalid,
	input  wire logic     s_axi_wready,
	input  wire logic     s_axi_bvalid,
	input  wire logic     s_axi_arvalid,
	input  wire logic     s_axi_arready,
	input  wire logic     s_axi_rvalid,
	input  wire logic     s_axi_rready,
	input  wire pmask_t   link_up,
	input  wire logic     req_valid,
	input  wire fwd_req_t req,
	input  wire logic     ans_valid,
	input  wire fwd_ans_t ans
);
	pmask_t lq_ff;
	always_ff @(posedge mclk) lq_ff <= link_up;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_ans_lat: assert property (req_valid |=> ans_valid)
		else $error("answer missing");
	a_ans_quiet: assert property (!req_valid |=> !ans_valid)
		else $error("answer without request");
	a_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& !s_axi_bvalid |=> ##1 s_axi_bvalid) else $error("write response late");
	a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address open while busy");
	a_rd_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read not closed");
	a_egress_linked: assert property (ans_valid && !ans.drop |-> lq_ff[ans.egress])
		else $error("egress on a dead link");
	a_bad_port: assert property (req_valid && req.lport >= PORT_LIMIT |=> ans.drop)
		else $error("bad port not dropped");
	c_drop: cover property (ans_valid && ans.drop);
	c_write: cover property (s_axi_bvalid && s_axi_wready);
	c_pass: cover property (ans_valid && !ans.drop);
endmodule
bind link_aggregation_port_select lag_monitor u_mon (.*);

/* tb/testbench.sv */
// Self-checking bench: AXI4-Lite setup of trunk groups, then lookups.
// Assumes lag_pkg and the link peer model are compiled first.
`timescale 1ns/1ps
module testbench;
	import lag_pkg::*;
	logic mclk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, req_valid = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ans_valid;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	pmask_t      link_up, port_fwd, cut = 0, stp_fwd = 28'h0000004;
	pidx_t [NPORT-1:0] port_lport;
	fwd_req_t    req = 0;
	fwd_ans_t    ans, a;
	logic [47:0] da [3] = '{48'h0123_4567_89ab, 48'h00aa_0055_00ff, 48'h1111_2222_3377};
	int n_errors = 0, comparisons = 0, cyc = 0;
	link_aggregation_port_select u_dut (.*);
	link_peer u_peer (.mclk(mclk), .cut(cut), .link_up(link_up));
	initial forever #5 mclk = ~mclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
		s_axi_awaddr <= ad;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] ad);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge mclk);
	endtask
	task automatic lk(input logic [47:0] dst, input pidx_t lp);
		req_valid <= 1;
		req <= '{dst, lp};
		@(posedge mclk);
		req_valid <= 0;
		// The answer stands in the cycle that ends at this edge
		@(posedge mclk);
		a = ans;
		chk(ans_valid, 1);
	endtask
	function automatic pidx_t pick(input pmask_t m, input logic [47:0] dst);
		logic [7:0] h;
		int c;
		h = 0;
		c = 0;
		pick = 0;
		for (int i = 0; i < 6; i++) h ^= dst[8*i +: 8];
		for (int i = 0; i < NPORT; i++) if (m[i]) begin
			if (c == h % $countones(m)) pick = pidx_t'(i);
			c++;
		end
	endfunction
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			end_sim();
		end
	end
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1;
		// Uniform member settings and no locking or mirroring are the caller's duty
		wr(8'h00, 32'h201);
		wr(8'h04, 32'h2c);
		wr(8'h08, 32'ha01);
		wr(8'h0c, 32'h7fc00);
		rd(8'h34);
		chk(d, 32'h201);
		rd(8'h04);
		chk(d, 32'h2c);
		rd(8'h40);
		chk(d, RST_WORD);
		chk({30'h0, r}, {30'h0, RESP_SLV});
		wr(8'h40, 32'h1);
		chk({30'h0, r}, {30'h0, RESP_SLV});
		repeat (2) @(posedge mclk);
		chk(port_lport[5], 2);
		chk(port_lport[3], 2);
		chk(port_fwd[5:3], 3'h5);
		chk(port_fwd[6], 0);
		for (int i = 0; i < 6; i++) begin
			lk(da[i % 3], 2);
			chk(a, {pick(28'h2c, da[i % 3]), 1'b0});
		end
		cut <= 28'h8;
		repeat (2) @(posedge mclk);
		for (int i = 0; i < 3; i++) begin
			lk(da[i], 2);
			chk(a, {pick(28'h24, da[i]), 1'b0});
		end
		lk(da[0], 10);
		chk(a, {5'd10, 1'b0});
		lk(da[0], 3);
		chk(a, {5'd3, 1'b1});
		lk(da[0], 5'h1c);
		chk(a[0], 1);
		end_sim();
	end
endmodule
